// [ssc_baud_gen.sv]
`timescale 1ns/1ps
module ssc_baud_gen (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link to the channel core
  ssc_clk_if.gen bg
);

  logic [4:0] pre_reg;
  logic [7:0] cnt_reg;
  logic src_tick;

  // prescaler runs free so the selected source keeps its phase
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_reg <= 5'h00;
    end else begin
      pre_reg <= pre_reg + 5'h01;
    end
  end

  always_comb begin
    case (bg.count_src)
      ssc_pkg::SSC_SRC_F8: src_tick = ((pre_reg & ssc_pkg::SSC_PRE_F8_MASK) ==
                                       ssc_pkg::SSC_PRE_F8_MASK);
      ssc_pkg::SSC_SRC_F32: src_tick = (pre_reg == ssc_pkg::SSC_PRE_F32_MASK);
      default: src_tick = 1'b1;
    endcase
  end

  // one half period is n+1 source ticks, so a full bit is 2(n+1)
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= ssc_pkg::SSC_BAUD_RST;
      bg.half_tick <= 1'b0;
    end else if (bg.restart) begin
      cnt_reg <= ssc_pkg::SSC_BAUD_RST;
      bg.half_tick <= 1'b0;
    end else if (src_tick && (cnt_reg >= bg.divider)) begin
      cnt_reg <= ssc_pkg::SSC_BAUD_RST;
      bg.half_tick <= 1'b1;
    end else begin
      cnt_reg <= src_tick ? cnt_reg + 8'h01 : cnt_reg;
      bg.half_tick <= 1'b0;
    end
  end

endmodule

// [ssc_clk_if.sv]
`timescale 1ns/1ps
interface ssc_clk_if;
  logic restart;
  logic [1:0] count_src;
  logic [7:0] divider;
  logic half_tick;

  modport gen (
    input restart,
    input count_src,
    input divider,
    output half_tick
  );

  modport core (
    output restart,
    output count_src,
    output divider,
    input half_tick
  );
endinterface

// [ssc_peer.sv]
`timescale 1ns/1ps
module ssc_peer (
  // system clock and link
  input wire logic i_sys_clk,
  input wire logic i_sck,
  input wire logic i_txd,
  // word format
  input wire logic i_pol,
  input wire logic i_msb,
  input wire logic [7:0] i_word,
  // peer outputs
  output logic o_rxd,
  output logic o_sck,
  output logic [7:0] o_got
);
  logic last;
  logic pol_q;
  logic [2:0] cnt;
  logic [2:0] idx;
  initial begin
    o_rxd = 1'b0;
    o_sck = 1'b1;
    o_got = 8'h00;
    last = 1'b1;
    pol_q = 1'b0;
    cnt = 3'h0;
  end
  assign idx = i_msb ? 3'h7 - cnt : cnt;
  always @(posedge i_sys_clk) begin
    last <= i_sck;
    pol_q <= i_pol;
    if (last != i_sck && i_sck == i_pol) o_rxd <= i_word[idx];
    if (last != i_sck && i_sck != i_pol) begin
      o_got[idx] <= i_txd;
      cnt <= cnt + 3'h1;
      // line released after the word: show the inverse, not a held bit
      if (cnt == 3'h7) o_rxd <= ~o_rxd;
    end
    // a polarity change moves the idle level, which is no edge
    if (pol_q != i_pol) cnt <= 3'h0;
  end
  // clock parked high between words, polarity 0 only
  task automatic burst(input int h);
    repeat (16) begin
      repeat (h) @(posedge i_sys_clk);
      o_sck <= ~o_sck;
    end
  endtask
endmodule

// [ssc_pkg.sv]
package ssc_pkg;

  // register byte addresses on the avalon slave
  localparam logic [4:0] SSC_ADDR_MODE = 5'h00;
  localparam logic [4:0] SSC_ADDR_BAUD = 5'h04;
  localparam logic [4:0] SSC_ADDR_CTRL0 = 5'h08;
  localparam logic [4:0] SSC_ADDR_CTRL1 = 5'h0c;
  localparam logic [4:0] SSC_ADDR_TXBUF = 5'h10;
  localparam logic [4:0] SSC_ADDR_RXBUF = 5'h14;

  // channel_mode_register fields
  localparam int SSC_MODE_LSB = 0;
  localparam int SSC_MODE_MSB = 2;
  localparam int SSC_MODE_CLOCK_SOURCE_DIRECTION_BIT = 3;
  localparam logic [2:0] SSC_MODE_SYNC = 3'h1;
  localparam logic [2:0] SSC_MODE_RST = 3'h0;

  // control_register_zero fields
  localparam int SSC_C0_SRC_LSB = 0;
  localparam int SSC_C0_SRC_MSB = 1;
  localparam int SSC_C0_TX_SHIFT_EMPTY_FLAG_BIT = 3;
  localparam int SSC_C0_NCH_BIT = 5;
  localparam int SSC_C0_POL_BIT = 6;
  localparam int SSC_C0_ORDER_BIT = 7;

  // control_register_one fields
  localparam int SSC_C1_TE_BIT = 0;
  localparam int SSC_C1_TI_BIT = 1;
  localparam int SSC_C1_RE_BIT = 2;
  localparam int SSC_C1_RI_BIT = 3;
  localparam int SSC_C1_IRS_BIT = 4;
  localparam int SSC_C1_RRM_BIT = 5;

  // receive_buffer fields
  localparam int SSC_RB_OER_BIT = 12;

  // divider count source codes and prescaler masks
  localparam logic [1:0] SSC_SRC_F1 = 2'h0;
  localparam logic [1:0] SSC_SRC_F8 = 2'h1;
  localparam logic [1:0] SSC_SRC_F32 = 2'h2;
  localparam logic [4:0] SSC_PRE_F8_MASK = 5'h07;
  localparam logic [4:0] SSC_PRE_F32_MASK = 5'h1f;

  // reset values and bit counts
  localparam logic [7:0] SSC_BAUD_RST = 8'h00;
  localparam logic [7:0] SSC_BYTE_RST = 8'h00;
  localparam logic [2:0] SSC_BIT_LAST = 3'h7;
  localparam logic [2:0] SSC_BIT_OVR = 3'h6;

  typedef enum logic [1:0] {
    SSC_IDLE = 2'b00,
    SSC_LEAD = 2'b01,
    SSC_TRAIL = 2'b10
  } ssc_state_t;

endpackage

// [ssc_top.sv]
`timescale 1ns/1ps
module ssc_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // serial link pins
  output logic o_txd_out,
  output logic o_txd_oe,
  input wire logic i_rxd,
  input wire logic i_clk_in,
  output logic o_clk_out,
  output logic o_clk_oe,
  // interrupt requests to the interrupt controller
  output logic o_tx_irq,
  output logic o_rx_irq
);

  logic rst_meta_reg;
  logic rst_n_reg;

  // registers
  logic [2:0] mode_reg;
  logic clock_source_direction_reg;
  logic [7:0] baud_reg;
  logic [1:0] src_reg;
  logic nch_reg;
  logic pol_reg;
  logic order_reg;
  logic te_reg;
  logic re_reg;
  logic irs_reg;
  logic rrm_reg;
  logic [7:0] txbuf_reg;
  logic [7:0] rxbuf_reg;
  logic ti_reg;
  logic ri_reg;
  logic oer_reg;
  logic tx_shift_empty_flag_reg;

  // transfer engine
  ssc_pkg::ssc_state_t state_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_shift_reg;
  logic [2:0] bit_reg;
  logic rx_on_reg;
  logic word_ovr_reg;
  logic clk_prev_reg;

  logic sync_mode;
  logic acc;
  logic wr_ok;
  logic wr_tb;
  logic rd_rb;
  logic start;
  logic lead_evt;
  logic trail_evt;
  logic word_done;
  logic bit_in;
  logic [31:0] rdata_next;

  ssc_clk_if bgi ();

  ssc_baud_gen u_baud (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n_reg),
    .bg(bgi.gen)
  );

  // reset release through two flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  assign sync_mode = (mode_reg == ssc_pkg::SSC_MODE_SYNC);
  // second cycle of a request is the one the master completes on
  assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign wr_ok = acc && i_avs_write && i_avs_byteenable[0];
  assign wr_tb = wr_ok && (i_avs_address == ssc_pkg::SSC_ADDR_TXBUF);
  assign rd_rb = acc && i_avs_read && (i_avs_address == ssc_pkg::SSC_ADDR_RXBUF);
  // blocked during a buffer write so a fresh word is never lost
  assign start = sync_mode && te_reg && !ti_reg && !wr_tb && (state_reg == ssc_pkg::SSC_IDLE);
  assign bit_in = i_rxd;

  // edge events; internal ticks alternate lead and trail
  always_comb begin
    if (!clock_source_direction_reg) begin
      lead_evt = bgi.half_tick && (state_reg == ssc_pkg::SSC_LEAD);
      trail_evt = bgi.half_tick && (state_reg == ssc_pkg::SSC_TRAIL);
    end else begin
      // relies on the peer parking its clock at the idle level
      lead_evt = (clk_prev_reg != pol_reg) && (i_clk_in == pol_reg) &&
                 (state_reg == ssc_pkg::SSC_LEAD);
      trail_evt = (clk_prev_reg == pol_reg) && (i_clk_in != pol_reg) &&
                  (state_reg == ssc_pkg::SSC_TRAIL);
    end
  end

  assign word_done = trail_evt && (bit_reg == ssc_pkg::SSC_BIT_LAST);

  assign bgi.restart = start;
  assign bgi.count_src = src_reg;
  assign bgi.divider = baud_reg;

  // avalon: one wait state, then the request completes
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      o_avs_readdata <= rdata_next;
    end
  end

  // unused bits read as zero; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (i_avs_address)
      ssc_pkg::SSC_ADDR_MODE: begin
        rdata_next[ssc_pkg::SSC_MODE_MSB:ssc_pkg::SSC_MODE_LSB] = mode_reg;
        rdata_next[ssc_pkg::SSC_MODE_CLOCK_SOURCE_DIRECTION_BIT] = clock_source_direction_reg;
      end
      ssc_pkg::SSC_ADDR_BAUD: rdata_next[7:0] = baud_reg;
      ssc_pkg::SSC_ADDR_CTRL0: begin
        rdata_next[ssc_pkg::SSC_C0_SRC_MSB:ssc_pkg::SSC_C0_SRC_LSB] = src_reg;
        rdata_next[ssc_pkg::SSC_C0_TX_SHIFT_EMPTY_FLAG_BIT] = tx_shift_empty_flag_reg;
        rdata_next[ssc_pkg::SSC_C0_NCH_BIT] = nch_reg;
        rdata_next[ssc_pkg::SSC_C0_POL_BIT] = pol_reg;
        rdata_next[ssc_pkg::SSC_C0_ORDER_BIT] = order_reg;
      end
      ssc_pkg::SSC_ADDR_CTRL1: begin
        rdata_next[ssc_pkg::SSC_C1_TE_BIT] = te_reg;
        rdata_next[ssc_pkg::SSC_C1_TI_BIT] = ti_reg;
        rdata_next[ssc_pkg::SSC_C1_RE_BIT] = re_reg;
        rdata_next[ssc_pkg::SSC_C1_RI_BIT] = ri_reg;
        rdata_next[ssc_pkg::SSC_C1_IRS_BIT] = irs_reg;
        rdata_next[ssc_pkg::SSC_C1_RRM_BIT] = rrm_reg;
      end
      ssc_pkg::SSC_ADDR_RXBUF: begin
        rdata_next[7:0] = rxbuf_reg;
        rdata_next[ssc_pkg::SSC_RB_OER_BIT] = oer_reg;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  // configuration writes; only defined bits are stored
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_reg <= ssc_pkg::SSC_MODE_RST;
      clock_source_direction_reg <= 1'b0;
      baud_reg <= ssc_pkg::SSC_BAUD_RST;
      src_reg <= ssc_pkg::SSC_SRC_F1;
      nch_reg <= 1'b0;
      pol_reg <= 1'b0;
      order_reg <= 1'b0;
      te_reg <= 1'b0;
      re_reg <= 1'b0;
      irs_reg <= 1'b0;
      rrm_reg <= 1'b0;
    end else if (wr_ok) begin
      case (i_avs_address)
        ssc_pkg::SSC_ADDR_MODE: begin
          mode_reg <= i_avs_writedata[ssc_pkg::SSC_MODE_MSB:ssc_pkg::SSC_MODE_LSB];
          clock_source_direction_reg <= i_avs_writedata[ssc_pkg::SSC_MODE_CLOCK_SOURCE_DIRECTION_BIT];
        end
        ssc_pkg::SSC_ADDR_BAUD: baud_reg <= i_avs_writedata[7:0];
        ssc_pkg::SSC_ADDR_CTRL0: begin
          src_reg <= i_avs_writedata[ssc_pkg::SSC_C0_SRC_MSB:ssc_pkg::SSC_C0_SRC_LSB];
          nch_reg <= i_avs_writedata[ssc_pkg::SSC_C0_NCH_BIT];
          pol_reg <= i_avs_writedata[ssc_pkg::SSC_C0_POL_BIT];
          order_reg <= i_avs_writedata[ssc_pkg::SSC_C0_ORDER_BIT];
        end
        ssc_pkg::SSC_ADDR_CTRL1: begin
          te_reg <= i_avs_writedata[ssc_pkg::SSC_C1_TE_BIT];
          re_reg <= i_avs_writedata[ssc_pkg::SSC_C1_RE_BIT];
          irs_reg <= i_avs_writedata[ssc_pkg::SSC_C1_IRS_BIT];
          rrm_reg <= i_avs_writedata[ssc_pkg::SSC_C1_RRM_BIT];
        end
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // transmit buffer and its empty flag
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      txbuf_reg <= ssc_pkg::SSC_BYTE_RST;
      ti_reg <= 1'b1;
    end else if (start) begin
      ti_reg <= 1'b1;
    end else if (wr_tb) begin
      txbuf_reg <= i_avs_writedata[7:0];
      ti_reg <= 1'b0;
    end else if (rd_rb && rrm_reg) begin
      // old buffer contents go out again as dummy data
      ti_reg <= 1'b0;
    end
  end

  // transfer sequencing
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ssc_pkg::SSC_IDLE;
      bit_reg <= 3'h0;
      tx_shift_empty_flag_reg <= 1'b1;
      rx_on_reg <= 1'b0;
    end else if (!sync_mode) begin
      state_reg <= ssc_pkg::SSC_IDLE;
      bit_reg <= 3'h0;
      tx_shift_empty_flag_reg <= 1'b1;
      rx_on_reg <= 1'b0;
    end else begin
      case (state_reg)
        ssc_pkg::SSC_IDLE: begin
          if (start) begin
            state_reg <= ssc_pkg::SSC_LEAD;
            bit_reg <= 3'h0;
            tx_shift_empty_flag_reg <= 1'b0;
            rx_on_reg <= re_reg;
          end
        end
        ssc_pkg::SSC_LEAD: begin
          if (lead_evt) begin
            state_reg <= ssc_pkg::SSC_TRAIL;
          end
        end
        ssc_pkg::SSC_TRAIL: begin
          if (word_done) begin
            state_reg <= ssc_pkg::SSC_IDLE;
            tx_shift_empty_flag_reg <= 1'b1;
          end else if (trail_evt) begin
            state_reg <= ssc_pkg::SSC_LEAD;
            bit_reg <= bit_reg + 3'h1;
          end
        end
        default: state_reg <= ssc_pkg::SSC_IDLE;
      endcase
    end
  end

  // shift registers, bit order applies both ways
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tx_shift_reg <= ssc_pkg::SSC_BYTE_RST;
      rx_shift_reg <= ssc_pkg::SSC_BYTE_RST;
    end else if (start) begin
      tx_shift_reg <= txbuf_reg;
    end else if (trail_evt) begin
      if (order_reg) begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        rx_shift_reg <= {rx_shift_reg[6:0], bit_in};
      end else begin
        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
        rx_shift_reg <= {bit_in, rx_shift_reg[7:1]};
      end
    end
  end

  // data output: changes on lead edge, high until first transfer
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_txd_out <= 1'b1;
      o_txd_oe <= 1'b0;
    end else begin
      if (!sync_mode) begin
        o_txd_out <= 1'b1;
      end else if (lead_evt) begin
        o_txd_out <= order_reg ? tx_shift_reg[7] : tx_shift_reg[0];
      end
      // open drain only pulls low; a high level floats
      if (!sync_mode) begin
        o_txd_oe <= 1'b0;
      end else if (nch_reg) begin
        o_txd_oe <= lead_evt ? !(order_reg ? tx_shift_reg[7] : tx_shift_reg[0])
                             : (o_txd_oe && !o_txd_out);
      end else begin
        o_txd_oe <= 1'b1;
      end
    end
  end

  // transfer clock pin
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_clk_out <= 1'b1;
      o_clk_oe <= 1'b0;
      clk_prev_reg <= 1'b1;
    end else begin
      clk_prev_reg <= i_clk_in;
      o_clk_oe <= sync_mode && !clock_source_direction_reg;
      if (lead_evt) begin
        o_clk_out <= pol_reg;
      end else if (trail_evt || (state_reg == ssc_pkg::SSC_IDLE)) begin
        o_clk_out <= !pol_reg;
      end
    end
  end

  // receive buffer, completion and overrun flags
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rxbuf_reg <= ssc_pkg::SSC_BYTE_RST;
      ri_reg <= 1'b0;
      oer_reg <= 1'b0;
      word_ovr_reg <= 1'b0;
    end else begin
      if (start) begin
        word_ovr_reg <= 1'b0;
      end else if (trail_evt && rx_on_reg && (bit_reg == ssc_pkg::SSC_BIT_OVR) && ri_reg) begin
        word_ovr_reg <= 1'b1;
      end
      if (!sync_mode || !re_reg) begin
        oer_reg <= 1'b0;
      end else if (trail_evt && rx_on_reg && (bit_reg == ssc_pkg::SSC_BIT_OVR) && ri_reg) begin
        oer_reg <= 1'b1;
      end
      if (word_done && rx_on_reg) begin
        rxbuf_reg <= order_reg ? {rx_shift_reg[6:0], bit_in}
                               : {bit_in, rx_shift_reg[7:1]};
        ri_reg <= 1'b1;
      end else if (rd_rb) begin
        ri_reg <= 1'b0;
      end
    end
  end

  // interrupt request pulses to the external controller
  always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_tx_irq <= 1'b0;
      o_rx_irq <= 1'b0;
    end else begin
      o_tx_irq <= irs_reg ? word_done : start;
      o_rx_irq <= word_done && rx_on_reg &&
                  !word_ovr_reg;
    end
  end

endmodule

// [ssc_top_monitor.sv]
`timescale 1ns/1ps
module ssc_top_monitor (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // serial link pins
  input wire logic o_txd_out,
  input wire logic o_txd_oe,
  input wire logic i_rxd,
  input wire logic i_clk_in,
  input wire logic o_clk_out,
  input wire logic o_clk_oe,
  // interrupt requests
  input wire logic o_tx_irq,
  input wire logic o_rx_irq
);
  logic [7:0] mode_reg, c0_reg, c1_reg, baud_reg;
  logic [1:0] age_reg;
  logic moved_reg;
  logic [15:0] gap_reg;
  logic wr_done;
  logic sync_md;
  logic sync_int;
  logic [15:0] half;
  assign wr_done = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  assign sync_md = mode_reg[2:0] == ssc_pkg::SSC_MODE_SYNC;
  assign sync_int = sync_md && !mode_reg[3];
  assign half = (16'(baud_reg) + 16'h1) * ((c0_reg[1:0] == ssc_pkg::SSC_SRC_F8) ? 16'h8 :
    (c0_reg[1:0] == ssc_pkg::SSC_SRC_F32) ? 16'h20 : 16'h1);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= 8'h00;
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      baud_reg <= 8'h00;
    end else if (wr_done) begin
      if (i_avs_address == ssc_pkg::SSC_ADDR_MODE) mode_reg <= i_avs_writedata[7:0];
      if (i_avs_address == ssc_pkg::SSC_ADDR_CTRL0) c0_reg <= i_avs_writedata[7:0];
      if (i_avs_address == ssc_pkg::SSC_ADDR_CTRL1) c1_reg <= i_avs_writedata[7:0];
      if (i_avs_address == ssc_pkg::SSC_ADDR_BAUD) baud_reg <= i_avs_writedata[7:0];
    end
  end
  // registered pins lag a config write, so checks wait for it to settle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_reg <= 2'h0;
    end else if (wr_done && i_avs_address <= ssc_pkg::SSC_ADDR_CTRL1) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  // set once a transfer may have begun since the last mode write
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      moved_reg <= 1'b0;
    end else if (wr_done && i_avs_address == ssc_pkg::SSC_ADDR_MODE) begin
      moved_reg <= 1'b0;
    end else if ((wr_done && i_avs_address == ssc_pkg::SSC_ADDR_TXBUF) ||
      (i_avs_read && !o_avs_waitrequest && i_avs_address == ssc_pkg::SSC_ADDR_RXBUF)) begin
      moved_reg <= 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_reg <= 16'h1;
    end else if ($changed(o_clk_out)) begin
      gap_reg <= 16'h1;
    end else if (gap_reg != 16'hffff) begin
      gap_reg <= gap_reg + 16'h1;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_clk_source: assert property (age_reg == 2'h3 |-> o_clk_oe == sync_int)
    else $error("clock pin drive does not follow mode and source");
  a_idle_drive: assert property (age_reg == 2'h3 && sync_md && !c0_reg[5] && !moved_reg
    |-> o_txd_out && o_txd_oe) else $error("idle data pin not driven high");
  a_idle_release: assert property (age_reg == 2'h3 && sync_md && c0_reg[5] && !moved_reg
    |-> !o_txd_oe) else $error("idle open-drain data pin not released");
  a_od_no_high: assert property (age_reg == 2'h3 && sync_md && c0_reg[5]
    |-> !(o_txd_oe && o_txd_out)) else $error("open-drain pin drives high");
  a_clk_parked: assert property (age_reg == 2'h3 && sync_int && !moved_reg
    |-> o_clk_out == !c0_reg[6]) else $error("idle clock at wrong level");
  a_half_period: assert property (age_reg == 2'h3 && sync_int && $past(o_clk_oe) &&
    $changed(o_clk_out) && o_clk_out == !c0_reg[6] |-> gap_reg == half)
    else $error("clock half period wrong");
  a_te_gates_clk: assert property (age_reg == 2'h3 && !c1_reg[0] |=> $stable(o_clk_out))
    else $error("clock toggles with transmit disabled");
  a_rx_needs_en: assert property (o_rx_irq |-> c1_reg[2] && c1_reg[0])
    else $error("receive irq without both enables");
  a_tx_irq_pulse: assert property (o_tx_irq |=> !o_tx_irq)
    else $error("transmit irq longer than one cycle");
endmodule

bind ssc_top ssc_top_monitor ssc_top_monitor_i (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_txd_out(o_txd_out), .o_txd_oe(o_txd_oe),
  .i_rxd(i_rxd), .i_clk_in(i_clk_in), .o_clk_out(o_clk_out), .o_clk_oe(o_clk_oe),
  .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq)
);

// [ssc_top_test.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ssc_top_test;
  typedef struct {
    logic [7:0] c0;
    logic [7:0] baud;
    logic [7:0] tx;
    logic [7:0] rx;
  } ssc_row_t;
  localparam logic [4:0] MD = ssc_pkg::SSC_ADDR_MODE;
  localparam logic [4:0] BD = ssc_pkg::SSC_ADDR_BAUD;
  localparam logic [4:0] C0 = ssc_pkg::SSC_ADDR_CTRL0;
  localparam logic [4:0] C1 = ssc_pkg::SSC_ADDR_CTRL1;
  localparam logic [4:0] TB = ssc_pkg::SSC_ADDR_TXBUF;
  localparam logic [4:0] RB = ssc_pkg::SSC_ADDR_RXBUF;
  // ctrl0, divider, word sent, word the peer returns
  ssc_row_t rows [5] = '{
    '{8'h81, 8'h03, 8'h12, 8'h80},
    '{8'h40, 8'h04, 8'h01, 8'hfe},
    '{8'hc2, 8'h00, 8'h7f, 8'h55},
    '{8'h23, 8'h02, 8'hc6, 8'h69},
    '{8'h00, 8'h03, 8'ha5, 8'h3c}
  };
  logic i_sys_clk, i_rst_n, rd, wr, pol_b, msb_b, ext_b, rxd, peer_sck, sck, txd_line;
  logic wreq, txd, txd_oe, clk_out, clk_oe, tx_irq, rx_irq;
  logic [4:0] addr;
  logic [31:0] wdata, q, rdata;
  logic [7:0] word_b, got;
  int err_total, num_checks, rx_cnt, tx_cnt, base, b2;
  // open-drain data line needs the pull-up
  assign txd_line = txd_oe ? txd : 1'b1;
  assign sck = clk_oe ? clk_out : (ext_b ? peer_sck : !pol_b);
  ssc_top ssc_top_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_txd_out(txd), .o_txd_oe(txd_oe),
    .i_rxd(rxd), .i_clk_in(sck), .o_clk_out(clk_out), .o_clk_oe(clk_oe),
    .o_tx_irq(tx_irq), .o_rx_irq(rx_irq)
  );
  ssc_peer ssc_peer_i (
    .i_sys_clk(i_sys_clk), .i_sck(sck), .i_txd(txd_line), .i_pol(pol_b), .i_msb(msb_b),
    .i_word(word_b), .o_rxd(rxd), .o_sck(peer_sck), .o_got(got)
  );
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (rx_irq === 1'b1) rx_cnt++;
    if (tx_irq === 1'b1) tx_cnt++;
  end
  task results;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge i_sys_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      err_total++;
      results;
    end
  endtask
  task wait_ev(input bit s, input int b);
    int n;
    n = 0;
    while ((s ? tx_cnt : rx_cnt) == b && n < 20000) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      results;
    end
  endtask
  task xfer(input ssc_row_t r);
    bus(1'b1, MD, 32'h0);
    bus(1'b1, C0, {24'h0, r.c0});
    bus(1'b1, BD, {24'h0, r.baud});
    bus(1'b1, C1, 32'h5);
    pol_b <= r.c0[6];
    msb_b <= r.c0[7];
    word_b <= r.rx;
    bus(1'b1, MD, 32'h1);
    base = rx_cnt;
    b2 = tx_cnt;
    bus(1'b1, TB, {24'h0, r.tx});
    wait_ev(1'b0, base);
    bus(1'b0, RB, 32'h0);
    `CHK(q[7:0], r.rx)
    `CHK(got, r.tx)
    `CHK(q[12], 1'b0)
    `CHK(tx_cnt, b2 + 1)
  endtask
  initial begin
    i_rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    pol_b = 1'b0;
    msb_b = 1'b0;
    ext_b = 1'b0;
    word_b = 8'h00;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    bus(1'b0, C1, 32'h0);
    `CHK(q, 32'h2)
    bus(1'b0, 5'h18, 32'h0);
    `CHK(q, 32'h0)
    foreach (rows[i]) xfer(rows[i]);
    // transmit only: no reception, tx irq at completion
    bus(1'b1, C1, 32'h11);
    base = tx_cnt;
    b2 = rx_cnt;
    bus(1'b1, TB, 32'h96);
    wait_ev(1'b1, base);
    `CHK(rx_cnt, b2)
    `CHK(got, 8'h96)
    // peer supplies the clock
    bus(1'b1, MD, 32'h0);
    bus(1'b1, C1, 32'h5);
    ext_b <= 1'b1;
    word_b <= 8'h3e;
    bus(1'b1, MD, 32'h9);
    base = rx_cnt;
    bus(1'b1, TB, 32'h81);
    ssc_peer_i.burst(4);
    wait_ev(1'b0, base);
    bus(1'b0, RB, 32'h0);
    `CHK(q[7:0], 8'h3e)
    `CHK(got, 8'h81)
    bus(1'b1, MD, 32'h1);
    ext_b <= 1'b0;
    // second word lands while the first is unread
    bus(1'b1, C1, 32'h15);
    word_b <= 8'h5a;
    b2 = rx_cnt;
    base = tx_cnt;
    bus(1'b1, TB, 32'h11);
    wait_ev(1'b1, base);
    base = tx_cnt;
    bus(1'b1, TB, 32'h22);
    wait_ev(1'b1, base);
    `CHK(rx_cnt, b2 + 1)
    bus(1'b0, RB, 32'h0);
    `CHK(q[12], 1'b1)
    // a receive buffer read alone restarts the link
    bus(1'b1, C1, 32'h25);
    word_b <= 8'hc3;
    base = rx_cnt;
    bus(1'b0, RB, 32'h0);
    wait_ev(1'b0, base);
    bus(1'b0, RB, 32'h0);
    `CHK(q[7:0], 8'hc3)
    results;
  end
endmodule
